/* File: core/ir_timer_pkg.sv */
// Package for the eight-bit timer, capture and hold register block.
// Assumes an 8-bit register port with one-cycle read latency.
package ir_timer_pkg;
   // Register offsets
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_T8_LOW_HOLD = 4'h4;
   localparam logic [3:0] OFF_T8_HIGH_HOLD = 4'h5;
   localparam logic [3:0] OFF_T16_HOLD_LO = 4'h6;
   localparam logic [3:0] OFF_T16_HOLD_HI = 4'h7;
   localparam logic [3:0] OFF_WIDE_CAP_LO = 4'h8;
   localparam logic [3:0] OFF_WIDE_CAP_HI = 4'h9;
   localparam logic [3:0] OFF_NARROW_CAP_LO = 4'hA;
   localparam logic [3:0] OFF_NARROW_CAP_HI = 4'hB;
   // Control field positions
   localparam int BIT_RUN = 7;
   localparam int BIT_SINGLE = 6;
   localparam int BIT_TIMEOUT = 5;
   localparam int BIT_CLKSEL_HI = 4;
   localparam int BIT_CLKSEL_LO = 3;
   localparam int BIT_CAP_MASK = 2;
   localparam int BIT_TO_MASK = 1;
   localparam int BIT_PIN_SEL = 0;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // Prescaler width: divide by up to 8
   localparam int PRESCALE_W = 3;

   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // Interrupt request pair
   typedef struct packed {
      logic capture;
      logic timeout;
   } irq_t;
endpackage : ir_timer_pkg

/* File: core/count_tick_gen.sv */
// Count-clock enable generator: divides the system clock by 1, 2, 4 or 8.
// Assumes a single clock; the divider runs freely and is not cleared at enable.
module count_tick_gen
   import ir_timer_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Control
   input wire logic run,
   input wire logic [1:0] clkSel,
   // Tick out
   output logic tick
);
   // Free prescaler; a running divider means the first tick after enable
   // may come early, which the timer tolerates.
   logic [PRESCALE_W-1:0] div_reg;
   logic [PRESCALE_W-1:0] divMask;

   // Mask of low bits that must be all ones for a tick
   assign divMask = (clkSel == 2'b00) ? 3'h0 :
                    (clkSel == 2'b01) ? 3'h1 :
                    (clkSel == 2'b10) ? 3'h3 : 3'h7;
   assign tick = run && ((div_reg & divMask) == divMask);

   // Divider counter
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_reg <= 3'h0;
      end else begin
         div_reg <= div_reg + 3'h1;
      end
   end
endmodule : count_tick_gen

/* File: core/ir_timer8.sv */
// Eight-bit counter/timer with control, hold and capture registers.
// Assumes an 8-bit register port; sixteen-bit capture values come in
// from the wide timer and are only presented here.
module ir_timer8
   import ir_timer_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Register port
   input wire reg_req_t regReq,
   output logic [7:0] rdata,
   // Common control inputs
   input wire logic demodMode,
   input wire logic edgeEvent,
   input wire logic demodIn,
   // Wide timer capture values
   input wire logic [15:0] wideCapture,
   // Wide timer hold value out
   output logic [15:0] wideHold,
   // Pin and interrupts
   input wire logic portOut,
   output logic timerPin,
   output irq_t irq
);
   // Control and data registers
   logic [7:0] ctrl_reg;
   logic [7:0] lowHold_reg;
   logic [7:0] highHold_reg;
   logic [7:0] wideLo_reg;
   logic [7:0] wideHi_reg;
   logic [7:0] capLo_reg;
   logic [7:0] capHi_reg;
   logic [7:0] count_reg;
   logic level_reg; // Which hold value is loaded
   logic out_reg; // Timer output level
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic tick;
   logic terminal;
   logic captureEvent;
   logic ctrlWr;
   logic [7:0] ctrl_next;

   // Write decode
   assign ctrlWr = regReq.wr && (regReq.addr == OFF_CTRL);
   // Terminal count reached on a count tick
   assign terminal = tick && (count_reg == 8'h00);
   // Capture only in demodulation mode
   assign captureEvent = demodMode && edgeEvent;

   // Count clock divider
   count_tick_gen u_tick (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .run(ctrl_reg[BIT_RUN]),
      .clkSel(ctrl_reg[BIT_CLKSEL_HI:BIT_CLKSEL_LO]),
      .tick(tick)
   );

   // Next control value: the flag's set wins over its clear
   always_comb begin
      ctrl_next = ctrl_reg;
      if (ctrlWr) begin
         ctrl_next = {regReq.wdata[7:6], ctrl_reg[BIT_TIMEOUT],
                      regReq.wdata[4:0]};
         if (regReq.wdata[BIT_TIMEOUT]) begin
            ctrl_next[BIT_TIMEOUT] = 1'b0;
         end
      end
      if (terminal) begin
         ctrl_next[BIT_TIMEOUT] = 1'b1;
         if (ctrl_reg[BIT_SINGLE]) begin
            ctrl_next[BIT_RUN] = 1'b0;
         end
      end
   end

   // Control register
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg <= CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // Hold registers, all plain read/write
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         lowHold_reg <= DATA_RESET;
         highHold_reg <= DATA_RESET;
         wideLo_reg <= DATA_RESET;
         wideHi_reg <= DATA_RESET;
      end else if (regReq.wr) begin
         case (regReq.addr)
            OFF_T8_LOW_HOLD: lowHold_reg <= regReq.wdata;
            OFF_T8_HIGH_HOLD: highHold_reg <= regReq.wdata;
            OFF_T16_HOLD_LO: wideLo_reg <= regReq.wdata;
            OFF_T16_HOLD_HI: wideHi_reg <= regReq.wdata;
            default: ;
         endcase
      end
   end
   assign wideHold = {wideHi_reg, wideLo_reg};

   // Down counter; alternates between low and high hold values
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= DATA_RESET;
         level_reg <= 1'b0;
         out_reg <= 1'b0;
      end else if (ctrlWr && regReq.wdata[BIT_RUN] && !ctrl_reg[BIT_RUN]) begin
         // Start loads the low-level count
         count_reg <= lowHold_reg;
         level_reg <= 1'b0;
      end else if (terminal) begin
         // Reload from the other hold value in modulo-N
         level_reg <= !level_reg;
         out_reg <= !out_reg;
         count_reg <= level_reg ? lowHold_reg : highHold_reg;
      end else if (captureEvent) begin
         count_reg <= DATA_RESET; // Restart measuring next level
      end else if (tick) begin
         count_reg <= count_reg - 8'h01;
      end
   end

   // Capture registers: cannot be written by software
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         capLo_reg <= DATA_RESET;
         capHi_reg <= DATA_RESET;
      end else if (captureEvent) begin
         // Level just ended is the inverse of the new level
         if (demodIn) begin
            capLo_reg <= count_reg;
         end else begin
            capHi_reg <= count_reg;
         end
      end
   end

   // Read mux, wide capture passed through
   always_comb begin
      case (regReq.addr)
         OFF_CTRL: rdata_next = ctrl_reg;
         OFF_T8_LOW_HOLD: rdata_next = lowHold_reg;
         OFF_T8_HIGH_HOLD: rdata_next = highHold_reg;
         OFF_T16_HOLD_LO: rdata_next = wideLo_reg;
         OFF_T16_HOLD_HI: rdata_next = wideHi_reg;
         OFF_WIDE_CAP_LO: rdata_next = wideCapture[7:0];
         OFF_WIDE_CAP_HI: rdata_next = wideCapture[15:8];
         OFF_NARROW_CAP_LO: rdata_next = capLo_reg;
         OFF_NARROW_CAP_HI: rdata_next = capHi_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= regReq.rd ? rdata_next : 8'h00;
      end
   end
   assign rdata = rdata_reg;

   // Pin routing and interrupt pulses
   assign timerPin = ctrl_reg[BIT_PIN_SEL] ? out_reg : portOut;
   assign irq.timeout = terminal && ctrl_reg[BIT_TO_MASK];
   assign irq.capture = captureEvent && ctrl_reg[BIT_CAP_MASK];

   // Checks
   sequence startSeq;
      ctrlWr && regReq.wdata[BIT_RUN];
   endsequence
   run_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      startSeq |=> ctrl_reg[BIT_RUN]) else $error("run not set");
   flag_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      terminal |=> ctrl_reg[BIT_TIMEOUT]) else $error("flag lost");
   flag_keep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ctrlWr && !regReq.wdata[BIT_TIMEOUT] && ctrl_reg[BIT_TIMEOUT]
      |=> ctrl_reg[BIT_TIMEOUT]) else $error("flag cleared by 0");
   single_stop_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      terminal && ctrl_reg[BIT_SINGLE] && !ctrlWr |=> !ctrl_reg[BIT_RUN])
      else $error("single pass kept running");
   cap_high_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      captureEvent && !demodIn |=> capHi_reg == $past(count_reg))
      else $error("high capture wrong");
   cap_ro_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !captureEvent |=> $stable(capLo_reg) && $stable(capHi_reg))
      else $error("capture changed");
   irq_to_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      irq.timeout == (terminal && ctrl_reg[BIT_TO_MASK]))
      else $error("timeout irq wrong");
   irq_cap_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !demodMode |-> !irq.capture) else $error("capture irq");
   pin_sel_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !ctrl_reg[BIT_PIN_SEL] |-> timerPin == portOut)
      else $error("pin routing");
   stop_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !ctrl_reg[BIT_RUN] |-> !tick) else $error("tick while stopped");
endmodule : ir_timer8

/* File: tb/ir_far_side.sv */
// Far-side model: qualified demodulator edges toward the timer block.
// Assumes edges arrive as one-cycle pulses on the system clock.
module ir_far_side (
   // Clock
   input wire logic ref_clk,
   // Demodulated input toward the block
   output logic edgeEvent,
   output logic demodIn
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle: no edge, line low
   initial begin
      edgeEvent = 1'b0;
      demodIn = 1'b0;
   end
   // One pulse, carrying the level that the edge leads into
   task automatic send_edge(input logic lvl);
      demodIn <= lvl;
      edgeEvent <= 1'b1;
      @(posedge ref_clk);
      edgeEvent <= 1'b0;
   endtask : send_edge
endmodule : ir_far_side

/* File: tb/ir_timer8_tb.sv */
// Self-checking bench for the eight-bit timer register block.
// Assumes one-cycle read latency and same-cycle interrupt pulses.
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
   n_mismatch++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); \
   end end
module ir_timer8_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ir_timer_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   reg_req_t regReq = '0;
   logic [7:0] rdata;
   logic demodMode = 1'b0;
   logic edgeEvent, demodIn, timerPin;
   logic [15:0] wideCapture = 16'h0000;
   logic [15:0] wideHold;
   logic portOut = 1'b0;
   irq_t irq;
   int n_mismatch = 0;
   int n_checks = 0;
   int toCnt = 0, capCnt = 0, n;
   logic [7:0] expQ[$]; // Pending read results, oldest first
   time toAt[$]; // Times of timeout pulses
   logic [7:0] hv[16] = '{default: 8'h00}; // Mirror of hold bytes
   logic [15:0] wc;
   logic [7:0] v, expV;
   logic rdSeen = 1'b0, toLast = 1'b0, pinLast = 1'b0, pinSel = 1'b0;
   // 25 MHz system clock
   always #20 ref_clk = ~ref_clk;
   ir_timer8 dut (.ref_clk(ref_clk), .reset_n(reset_n), .regReq(regReq),
      .rdata(rdata), .demodMode(demodMode), .edgeEvent(edgeEvent),
      .demodIn(demodIn), .wideCapture(wideCapture), .wideHold(wideHold),
      .portOut(portOut), .timerPin(timerPin), .irq(irq));
   ir_far_side far (.ref_clk(ref_clk), .edgeEvent(edgeEvent),
      .demodIn(demodIn));
   // Bus cycles hold the request until the next one replaces it
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      expQ.push_back(e);
      regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
   endtask : rd
   task automatic tk(input int c);
      regReq <= '0;
      repeat (c) @(posedge ref_clk);
   endtask : tk
   // Expected map: holds from mirror, wide capture from input, rest zero
   function automatic logic [7:0] exp_reg(input int a);
      if (a >= 4 && a < 8) return hv[a];
      if (a == 8) return wc[7:0];
      if (a == 9) return wc[15:8];
      return 8'h00;
   endfunction : exp_reg
   task automatic rd_all();
      for (int a = 0; a < 16; a++)
         rd(4'(a), exp_reg(a));
   endtask : rd_all
   task automatic end_sim();
      if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim
   // Strobe seen by the design at this edge; answer stands until the next
   always @(posedge ref_clk) begin
      rdSeen <= regReq.rd;
   end
   // Watcher on the falling edge, where outputs are settled, not racing
   always @(negedge ref_clk) begin
      if (rdSeen) begin
         expV = expQ.pop_front();
         `CHK(rdata, expV)
      end
      if (toLast) `CHK(timerPin, ~pinLast)
      if (irq.timeout === 1'b1) begin
         toCnt++;
         toAt.push_back($time);
      end
      if (irq.capture === 1'b1) capCnt++;
      toLast <= (irq.timeout === 1'b1) && pinSel;
      pinLast <= timerPin;
   end
   // Watchdog, far beyond the expected run length
   initial begin
      #2000000;
      n_mismatch++;
      end_sim();
   end
   initial begin
      void'($urandom(70));
      wc = 16'($urandom);
      wideCapture <= wc;
      portOut <= 1'($urandom);
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd_all();
      `CHK(timerPin, portOut)
      // Holds take random bytes, capture places ignore writes
      for (int a = 4; a < 12; a++) begin
         if (a < 8) hv[a] = 8'($urandom);
         wr(4'(a), a < 8 ? hv[a] : 8'($urandom));
      end
      rd_all();
      `CHK(wideHold, {hv[7], hv[6]})
      repeat (4) begin
         v = 8'($urandom) & 8'h5F;
         wr(OFF_CTRL, v);
         rd(OFF_CTRL, v);
      end
      // Modulo-N period per clock code; first period may be short
      wr(OFF_CTRL, 8'h00);
      wr(OFF_T8_LOW_HOLD, 8'h03);
      wr(OFF_T8_HIGH_HOLD, 8'h03);
      for (int c = 0; c < 4; c++) begin
         toAt.delete();
         v = 8'h83 | 8'(c << 3);
         pinSel <= 1'b1;
         wr(OFF_CTRL, v);
         tk(1);
         for (int i = 0; i < 200 && toAt.size() < 3; i++) @(posedge ref_clk);
         `CHK(toAt[2] - toAt[1], time'(160 << c))
         pinSel <= 1'b0;
         rd(OFF_CTRL, v | 8'h20);
         wr(OFF_CTRL, 8'h00);
         rd(OFF_CTRL, 8'h20);
         wr(OFF_CTRL, 8'h20);
         rd(OFF_CTRL, 8'h00);
      end
      // Single pass with timeout request masked
      wr(OFF_T8_LOW_HOLD, 8'h05);
      n = toCnt;
      wr(OFF_CTRL, 8'hC0);
      tk(30);
      rd(OFF_CTRL, 8'h60);
      tk(1);
      `CHK(toCnt, n)
      // Capture: both levels, then masked, then outside demodulation
      // Flag cleared by a plain write, never read-modify-write
      wr(OFF_CTRL, 8'h20);
      wr(OFF_CTRL, 8'h04);
      demodMode <= 1'b1;
      tk(1);
      far.send_edge(1'b1);
      tk(1);
      far.send_edge(1'b0);
      tk(1);
      `CHK(capCnt, 2)
      rd(OFF_NARROW_CAP_HI, 8'h00);
      wr(OFF_CTRL, 8'h00);
      tk(1);
      far.send_edge(1'b1);
      wr(OFF_CTRL, 8'h04);
      demodMode <= 1'b0;
      tk(1);
      far.send_edge(1'b0);
      tk(2);
      `CHK(capCnt, 2)
      end_sim();
   end
endmodule : ir_timer8_tb
